// ### common/ecs_pkg.sv
// Constants for the error code and status logic.
// Assumes a single clock domain; no imports, use ecs_pkg::name.
package ecs_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, 8-bit data in low bits)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CODE = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK = 4'h8;
    localparam logic [3:0] ADDR_CTRL = 4'hC;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] CODE_NONE = 8'h00;
    // ------------------------------------------------------------
    // Status byte and control register bit positions
    // ------------------------------------------------------------
    localparam int SB_PROG = 0;
    localparam int SB_HW = 3;
    localparam int SB_ERR = 5;
    localparam int SB_RQS = 6;
    localparam int CTRL_CLEAR = 0;
    // ------------------------------------------------------------
    // Error events, one bit each, lowest index wins on collision
    // ------------------------------------------------------------
    localparam int NUM_EV = 14;
    localparam int EV_SYNTAX = 0;
    localparam int EV_KEY_REMOTE = 1;
    localparam int EV_LOCAL_LOCKOUT = 2;
    localparam int EV_LIMIT = 3;
    localparam int EV_TONE_OFFSET = 4;
    localparam int EV_DISCRETE_SEQ = 5;
    localparam int EV_MARKER_SPAN = 6;
    localparam int EV_HV_FREQ = 7;
    localparam int EV_MOD_FREQ = 8;
    localparam int EV_NO_DISPLAY = 9;
    localparam int EV_UNITS_ZERO = 10;
    localparam int EV_UNITS_BAD = 11;
    localparam int EV_INCR_BAD = 12;
    localparam int EV_SWEEP_EQUAL = 13;
    // Codes in event order (decimal values as listed)
    localparam logic [7:0] CODE_SYNTAX = 8'h0A;
    localparam logic [7:0] CODE_KEY_REMOTE = 8'h0B;
    localparam logic [7:0] CODE_LOCAL_LOCKOUT = 8'h0C;
    localparam logic [7:0] CODE_LIMIT = 8'h14;
    localparam logic [7:0] CODE_TONE_OFFSET = 8'h15;
    localparam logic [7:0] CODE_DISCRETE_SEQ = 8'h17;
    localparam logic [7:0] CODE_MARKER_SPAN = 8'h18;
    localparam logic [7:0] CODE_HV_FREQ = 8'h19;
    localparam logic [7:0] CODE_MOD_FREQ = 8'h1A;
    localparam logic [7:0] CODE_NO_DISPLAY = 8'h28;
    localparam logic [7:0] CODE_UNITS_ZERO = 8'h32;
    localparam logic [7:0] CODE_UNITS_BAD = 8'h3C;
    localparam logic [7:0] CODE_INCR_BAD = 8'h46;
    localparam logic [7:0] CODE_SWEEP_EQUAL = 8'h5A;
    localparam logic [NUM_EV*8-1:0] CODE_TABLE = {
        CODE_SWEEP_EQUAL, CODE_INCR_BAD, CODE_UNITS_BAD, CODE_UNITS_ZERO,
        CODE_NO_DISPLAY, CODE_MOD_FREQ, CODE_HV_FREQ, CODE_MARKER_SPAN,
        CODE_DISCRETE_SEQ, CODE_TONE_OFFSET, CODE_LIMIT, CODE_LOCAL_LOCKOUT,
        CODE_KEY_REMOTE, CODE_SYNTAX};
endpackage : ecs_pkg

// ### design/ecs_error_status.sv
// Error code latch, status byte error bits and service request.
// Assumes fault pulses and commands come from logic on i_ref_clk;
// the register port is a plain strobe port with read data one cycle later.
//
// Overview of operation
// - Readout query returns code, clears code and bits
// - Any program or hardware error sets bit 5
// - Program error also sets bit 0
// - Hardware error also sets bit 3
// - Syntax or illegal character records code 10
// - Key pressed in remote records code 11
// - Local key under lockout records code 12
// - Out of limit value records code 20
// - Tone offset above limit records code 21
// - Discrete element save out of sequence: 23
// - Marker outside sweep span records code 24
// - Frequency too high with HV records 25
// - Frequency over modulation limit records code 26
// - Undisplayable value queried records code 40
// - Units conversion to zero records code 50
// - Improper units key or suffix records 60
// - Incompatible increment records code 70
// - Equal sweep start and stop records 90
// - Presets and clears also clear error bit
// - Service request when status AND mask nonzero
`timescale 1ns/1ps
module ecs_error_status #(
    parameter int NUM_EV = ecs_pkg::NUM_EV
) (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Fault events, one-cycle pulses, one bit per detected condition
    input wire logic [NUM_EV-1:0] i_prog_fault,
    input wire logic i_hw_fault,
    input wire logic [7:0] i_hw_code,
    // Remote commands, one-cycle pulses
    input wire logic i_fault_code_readout_cmd,
    input wire logic i_clear_cmd,
    // Other status byte bits kept elsewhere
    input wire logic [7:0] i_status_other,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Remote answer and status
    output logic [7:0] o_readout_data,
    output logic o_readout_valid,
    output logic [7:0] o_status_byte,
    output logic o_srq
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] code_reg, code_next;
    logic prog_reg, prog_next;
    logic hw_reg, hw_next;
    logic [7:0] mask_reg;
    logic [7:0] rdata_reg;
    logic [7:0] readout_reg;
    logic readout_valid_reg;
    logic [7:0] status_reg;
    logic srq_reg;

    // ------------------------------------------------------------
    // Event code selection, lowest index wins
    // ------------------------------------------------------------
    logic [7:0] pick [NUM_EV:0];
    assign pick[NUM_EV] = ecs_pkg::CODE_NONE;
    genvar g;
    generate
        // Ascending count keeps the loop variable non-negative
        for (g = 0; g < NUM_EV; g++) begin : g_pick
            // Priority chain: lower index overrides higher
            assign pick[g] = i_prog_fault[g] ? ecs_pkg::CODE_TABLE[g*8 +: 8] : pick[g+1];
        end
    endgenerate

    wire prog_event = |i_prog_fault;
    wire any_event = prog_event | i_hw_fault;
    // Hardware fault code takes precedence; it signals a real failure
    wire [7:0] event_code = i_hw_fault ? i_hw_code : pick[0];
    wire wr_ctrl_clr = i_wr && (i_addr == ecs_pkg::ADDR_CTRL) && i_wdata[ecs_pkg::CTRL_CLEAR];
    wire clear_all = i_clear_cmd | wr_ctrl_clr;
    wire readout = i_fault_code_readout_cmd;
    wire wr_mask = i_wr && (i_addr == ecs_pkg::ADDR_MASK);

    // ------------------------------------------------------------
    // Next state: a new event wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_comb begin
        code_next = code_reg;
        prog_next = prog_reg;
        hw_next = hw_reg;
        if (readout || clear_all) begin
            code_next = ecs_pkg::CODE_NONE;
            prog_next = 1'b0;
            hw_next = 1'b0;
        end
        if (any_event) begin
            code_next = event_code;
        end
        if (prog_event) begin
            prog_next = 1'b1;
        end
        if (i_hw_fault) begin
            hw_next = 1'b1;
        end
    end

    // Status byte composition from next values, so it tracks the flags
    wire err_next = prog_next | hw_next;
    wire [7:0] status_next = {i_status_other[7], 1'b0, err_next, i_status_other[4],
                              hw_next, i_status_other[2:1], prog_next};
    wire srq_next = |(status_next & mask_reg);
    wire [7:0] status_full = {status_next[7], srq_next, status_next[5:0]};

    // Register read decode
    wire [7:0] rd_mux = (i_addr == ecs_pkg::ADDR_CODE) ? code_reg :
                        (i_addr == ecs_pkg::ADDR_STATUS) ? status_reg :
                        (i_addr == ecs_pkg::ADDR_MASK) ? mask_reg : 8'h00;

    // ------------------------------------------------------------
    // Error flags and code
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            code_reg <= ecs_pkg::CODE_NONE;
            prog_reg <= 1'b0;
            hw_reg <= 1'b0;
        end else if (i_clk_en) begin
            code_reg <= code_next;
            prog_reg <= prog_next;
            hw_reg <= hw_next;
        end
    end

    // Readout answer carries the code held before clearing
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            readout_reg <= ecs_pkg::CODE_NONE;
            readout_valid_reg <= 1'b0;
        end else if (i_clk_en) begin
            readout_valid_reg <= readout;
            if (readout) begin
                readout_reg <= code_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Register port, mask and status outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            mask_reg <= ecs_pkg::MASK_RESET;
            rdata_reg <= 8'h00;
            status_reg <= 8'h00;
            srq_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (wr_mask) begin
                // Require service bit is always masked off
                mask_reg <= i_wdata & ~(8'h01 << ecs_pkg::SB_RQS);
            end
            rdata_reg <= i_rd ? rd_mux : 8'h00;
            status_reg <= status_full;
            srq_reg <= srq_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_readout_data = readout_reg;
    assign o_readout_valid = readout_valid_reg;
    assign o_status_byte = status_reg;
    assign o_srq = srq_reg;
endmodule : ecs_error_status

// ### dv/ecs_error_status_chk.sv
// Checker on the ports of the error code and status block.
// Assumes one clock domain; bound below to every block instance.
`timescale 1ns/1ps
module ecs_error_status_chk #(parameter int NUM_EV = 14) (
    // Clock and pulses
    input wire logic i_ref_clk, i_reset, i_clk_en, i_hw_fault, i_rd,
    input wire logic i_fault_code_readout_cmd, i_clear_cmd, o_readout_valid,
    // Data
    input wire logic [NUM_EV-1:0] i_prog_fault,
    input wire logic [7:0] i_hw_code, o_rdata, o_readout_data, o_status_byte
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // No fault racing a command, so the command alone decides
    wire logic calm = i_clk_en && !i_hw_fault && !(|i_prog_fault);
    wire logic [7:0] eb = o_status_byte & 8'h29;
    sequence s_ask; calm && i_fault_code_readout_cmd; endsequence
    sequence s_syn; i_clk_en && !i_hw_fault && i_prog_fault[0]; endsequence
    sequence s_hw; i_clk_en && i_hw_fault; endsequence
    property p_prog; i_clk_en && |i_prog_fault |=> eb[5] && eb[0]; endproperty
    a_prog: assert property (p_prog) else $error("prog bits");
    property p_hw; s_hw |=> eb[5] && eb[3]; endproperty
    a_hw: assert property (p_hw) else $error("hw bits");
    property p_ask; s_ask |=> o_readout_valid && eb == 8'h00; endproperty
    a_ask: assert property (p_ask) else $error("query");
    property p_syn; s_syn ##1 s_ask |=> o_readout_data == 8'h0A; endproperty
    a_syn: assert property (p_syn) else $error("syntax code");
    property p_hwc; s_hw ##1 s_ask |=> o_readout_data == $past(i_hw_code, 2); endproperty
    a_hwc: assert property (p_hwc) else $error("hw code");
    property p_clr; calm && i_clear_cmd |=> eb == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_one; $rose(o_readout_valid) |-> $past(i_fault_code_readout_cmd); endproperty
    a_one: assert property (p_one) else $error("answer unasked");
    property p_idle; $past(i_clk_en) && !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("rdata idle");
    property p_frz; !i_clk_en |=> $stable(o_status_byte) && $stable(o_readout_data); endproperty
    a_frz: assert property (p_frz) else $error("enable low but state moved");
endmodule : ecs_error_status_chk
bind ecs_error_status ecs_error_status_chk #(.NUM_EV(NUM_EV)) chk_u (.i_ref_clk, .i_reset,
    .i_clk_en, .i_hw_fault, .i_rd, .i_fault_code_readout_cmd, .i_clear_cmd, .o_readout_valid,
    .i_prog_fault, .i_hw_code, .o_rdata, .o_readout_data, .o_status_byte);

// ### dv/ecs_error_status_tb_top.sv
// Bench: every fault code, overwrites, clears, registers, service request.
// Assumes the remote controller model and the bound checker.
`timescale 1ns/1ps
module ecs_error_status_tb_top;
    logic clk = 1'b0, rst = 1'b1, en = 1'b1, hw = 1'b0, wr = 1'b0, rd = 1'b0, clr = 1'b0;
    logic go = 1'b0, rov, srq, qry, done;
    logic [13:0] pf = 14'h0000;
    logic [7:0] hc = 8'h00, oth = 8'h00, wd = 8'h00, rdat, rod, sb, code;
    logic [3:0] ad = 4'h0;
    logic [1:0] dly = 2'h0;
    int failures = 0, total_checks = 0, cyc = 0, k = 0, j = 0;
    localparam logic [7:0] CODES [14] = '{8'h0A, 8'h0B, 8'h0C, 8'h14, 8'h15, 8'h17,
        8'h18, 8'h19, 8'h1A, 8'h28, 8'h32, 8'h3C, 8'h46, 8'h5A};
    initial forever #2.5 clk = ~clk;
    ecs_error_status dut_u (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(en), .i_prog_fault(pf),
        .i_hw_fault(hw), .i_hw_code(hc), .i_fault_code_readout_cmd(qry), .i_clear_cmd(clr),
        .i_status_other(oth), .i_addr(ad), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
        .o_readout_data(rod), .o_readout_valid(rov), .o_status_byte(sb), .o_srq(srq));
    ecs_remote_ctrl host_u (.i_ref_clk(clk), .i_reset(rst), .i_go(go), .i_delay(dly),
        .i_readout_valid(rov), .i_readout_data(rod), .o_query(qry), .o_done(done), .o_code(code));
    function automatic logic [7:0] exp_code(int n);
        return CODES[n];
    endfunction : exp_code
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic fire(int n);
        @(posedge clk) pf <= 14'h0001 << n;
        @(posedge clk) pf <= 14'h0000;
        #1;
    endtask : fire
    task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
        @(posedge clk) {wr, rd, ad, wd} <= {w, !w, a, d};
        @(posedge clk) {wr, rd} <= 2'b00;
        #1;
    endtask : bus
    // Query through the model; bounded wait in case no answer comes
    task automatic ask(logic [7:0] exp);
        @(posedge clk) {go, dly} <= {1'b1, 2'($urandom)};
        @(posedge clk) go <= 1'b0;
        #1;
        for (int i = 0; i < 12 && !done; i++) begin
            @(posedge clk);
            #1;
        end
        chk(code, exp);
        chk(sb & 8'h29, 8'h00);
    endtask : ask
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            $display("Error %0t: timeout", $time);
            finish_test();
        end
    end
    initial begin
        void'($urandom(32'hCBAB4AF4));
        repeat (4) @(posedge clk);
        {rst, oth} <= {1'b0, 8'($urandom)};
        for (int n = 0; n < 14; n++) begin
            fire(n);
            chk(sb & 8'h29, 8'h21);
            ask(exp_code(n));
        end
        chk(sb & 8'h96, oth & 8'h96);
        $display("codes done");
        repeat (6) begin
            k = $urandom_range(13);
            j = $urandom_range(13);
            fire(k);
            fire(j);
            ask(exp_code(j));
        end
        @(posedge clk) {hw, hc} <= {1'b1, 8'($urandom)};
        @(posedge clk) hw <= 1'b0;
        #1;
        chk(sb & 8'h29, 8'h28);
        ask(hc);
        fire(3);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        #1;
        chk(sb & 8'h29, 8'h00);
        fire(7);
        bus(1'b1, 4'hC, 8'h01);
        chk(sb & 8'h29, 8'h00);
        $display("faults and clears done");
        fire(13);
        bus(1'b0, 4'h0, 8'h00);
        chk(rdat, 8'h5A);
        bus(1'b1, 4'h8, 8'hFF);
        bus(1'b0, 4'h8, 8'h00);
        chk(rdat, 8'hBF);
        bus(1'b0, 4'h2, 8'h00);
        chk(rdat, 8'h00);
        bus(1'b1, 4'h8, 8'h20);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, srq}, 8'h01);
        ask(8'h5A);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, srq}, 8'h00);
        // Enable low must hide a fault pulse completely
        @(posedge clk) en <= 1'b0;
        fire(2);
        chk(sb & 8'h29, 8'h00);
        @(posedge clk) en <= 1'b1;
        #1;
        $display("registers done");
        finish_test();
    end
endmodule : ecs_error_status_tb_top

// ### dv/ecs_remote_ctrl.sv
// Remote controller model: sends the readout query, keeps the answer.
// Assumes the answer comes back within a few cycles.
`timescale 1ns/1ps
module ecs_remote_ctrl (
    // Clock, reset, bench command
    input wire logic i_ref_clk, i_reset, i_go, i_readout_valid,
    input wire logic [1:0] i_delay,
    input wire logic [7:0] i_readout_data,
    // Query and captured code
    output logic o_query, o_done,
    output logic [7:0] o_code
);
    logic [2:0] wait_reg;
    // A pause of 0 to 3 cycles makes the query prompt or slow
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            {wait_reg, o_query, o_done, o_code} <= 13'h0000;
        end else begin
            o_query <= (wait_reg == 3'h1);
            wait_reg <= i_go ? {1'b0, i_delay} + 3'h1 : wait_reg - {2'h0, |wait_reg};
            o_done <= !i_go && (o_done || i_readout_valid);
            if (i_readout_valid) o_code <= i_readout_data;
        end
    end
endmodule : ecs_remote_ctrl
